// ---- core/ssdc_axis.v ----
// One axis: step edge detection, direction capture and microstep position
`timescale 1ns/1ns
`include "ssdc_consts.vh"
module ssdc_axis #(
  parameter POS_W = 32
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // Synchronised step and direction levels, resolution bit
  input wire step_i,
  input wire dir_i,
  input wire coarse_i,
  // Results
  output reg step_pulse_o,
  output reg dir_o,
  output reg [POS_W-1:0] pos_o,
  output reg [3:0] phase_o
);
  reg step_d_r;
  wire rise = step_i & ~step_d_r;
  wire [3:0] ustep = coarse_i ? `SSDC_USTEP_COARSE : `SSDC_USTEP_FINE;

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_d_r <= 1'b0;
      step_pulse_o <= 1'b0;
      dir_o <= 1'b0;
      pos_o <= {POS_W{1'b0}};
      phase_o <= 4'h0;
    end else begin
      step_d_r <= step_i;
      step_pulse_o <= rise;
      if (rise) begin
        dir_o <= dir_i;
        if (dir_i) begin
          pos_o <= pos_o + {{(POS_W-1){1'b0}}, 1'b1};
          phase_o <= (phase_o >= ustep - 4'h1) ? 4'h0 : phase_o + 4'h1;
        end else begin
          pos_o <= pos_o - {{(POS_W-1){1'b0}}, 1'b1};
          phase_o <= (phase_o == 4'h0) ? ustep - 4'h1 : phase_o - 4'h1;
        end
      end
    end
  end
endmodule

// ---- core/ssdc_top.v ----
// Step/direction input logic with configuration, current reduction and faults
// Summary of operation
// - A microstep happens only on a low-to-high step edge per axis.
// - Per-axis resolution bit: off gives ten, on gives five microsteps.
// - Two-bit C current code: low, 2.0A, 2.8A, 3.5A.
// - One bit sets XYZ current: off 2.2A, on 3.5A.
// - Aux 24V output: off means PWM oscillating motor, on means brake.
// - After 0.5 to 0.7 s without steps, drop to reduced current.
// - Flag overtemperature when temperature crosses the trip threshold.
// - While overtemperature, all six malfunction indicators flash in phase.
// - Ready only while the host watchdog line keeps toggling.
`timescale 1ns/1ns
`include "ssdc_consts.vh"
module ssdc_top #(
  parameter POS_W = 32,
  parameter IDLE_CYC = `SSDC_IDLE_CYC,
  parameter WDOG_CYC = `SSDC_WDOG_CYC,
  parameter FLASH_CYC = `SSDC_FLASH_CYC
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Parallel port pins: X, Y, Z, C
  input wire [3:0] step_i,
  input wire [3:0] dir_i,
  input wire watchdog_i,
  // Temperature comparator from the sensor front end
  input wire overtemp_i,
  // Drive controls
  output reg [3:0] step_pulse_o,
  output reg [3:0] dir_o,
  output reg [1:0] c_cur_code_o,
  output reg xyz_cur_hi_o,
  output reg cur_reduce_o,
  output reg aux_brake_o,
  output reg aux_pwm_en_o,
  // Indicators and interrupt
  output reg ready_o,
  output reg running_o,
  output reg [5:0] fault_led_o,
  output reg irq_o
);
  // Two-flop synchronisers for all pin inputs
  reg [9:0] sync1_r;
  reg [9:0] sync2_r;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
    end else begin
      sync1_r <= {overtemp_i, watchdog_i, dir_i, step_i};
      sync2_r <= sync1_r;
    end
  end
  wire [3:0] step_s = sync2_r[3:0];
  wire [3:0] dir_s = sync2_r[7:4];
  wire wdog_s = sync2_r[8];
  wire ovt_s = sync2_r[9];

  // Configuration, mirrors the switch bank
  reg [8:0] ctrl_r;
  reg [`SSDC_IRQ_W-1:0] irq_stat_r;
  reg [`SSDC_IRQ_W-1:0] irq_mask_r;

  // Axes: no rate limit inside; every synchronised rising edge counts up to 100 kHz and beyond
  wire [3:0] ax_pulse;
  wire [3:0] ax_dir;
  wire [POS_W-1:0] ax_pos [0:3];
  wire [3:0] ax_phase [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_axis
      ssdc_axis #(
        .POS_W(POS_W)
      ) u_axis (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .step_i(step_s[g]),
        .dir_i(dir_s[g]),
        .coarse_i(ctrl_r[`SSDC_CTRL_RES_LSB + g]),
        .step_pulse_o(ax_pulse[g]),
        .dir_o(ax_dir[g]),
        .pos_o(ax_pos[g]),
        .phase_o(ax_phase[g])
      );
    end
  endgenerate
  wire any_step = |ax_pulse;

  // Inactivity timer
  reg [31:0] idle_cnt_r;
  reg idle_r;
  wire idle_hit = (idle_cnt_r == IDLE_CYC - 1);
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt_r <= 32'h0;
      idle_r <= 1'b1;
    end else if (any_step) begin
      idle_cnt_r <= 32'h0;
      idle_r <= 1'b0;
    end else if (!idle_r) begin
      if (idle_hit) begin
        idle_r <= 1'b1;
      end else begin
        idle_cnt_r <= idle_cnt_r + 32'h1;
      end
    end
  end
  wire idle_set = ~idle_r & ~any_step & idle_hit;

  // Watchdog: each synchronised toggle restarts the window
  reg wdog_d_r;
  reg [31:0] wdog_cnt_r;
  reg wdog_ok_r;
  wire wdog_edge = wdog_s ^ wdog_d_r;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_d_r <= 1'b0;
      wdog_cnt_r <= 32'h0;
      wdog_ok_r <= 1'b0;
    end else begin
      wdog_d_r <= wdog_s;
      if (wdog_edge) begin
        wdog_cnt_r <= 32'h0;
        wdog_ok_r <= 1'b1;
      end else if (wdog_cnt_r == WDOG_CYC - 1) begin
        wdog_ok_r <= 1'b0;
      end else begin
        wdog_cnt_r <= wdog_cnt_r + 32'h1;
      end
    end
  end
  wire wdog_lost = wdog_ok_r & ~wdog_edge & (wdog_cnt_r == WDOG_CYC - 1);

  // Overtemperature: comparator level, fault while high, event on crossing
  reg ovt_d_r;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovt_d_r <= 1'b0;
    end else begin
      ovt_d_r <= ovt_s;
    end
  end
  wire ovt_rise = ovt_s & ~ovt_d_r;

  // Flash timer shared by all six indicators keeps them in phase
  reg [31:0] flash_cnt_r;
  reg flash_r;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_cnt_r <= 32'h0;
      flash_r <= 1'b0;
    end else if (!ovt_s) begin
      flash_cnt_r <= 32'h0;
      flash_r <= 1'b0;
    end else if (flash_cnt_r == FLASH_CYC - 1) begin
      flash_cnt_r <= 32'h0;
      flash_r <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  // APB: zero wait states, error on unmapped address
  wire apb_acc = psel_i & penable_i;
  wire apb_wr = apb_acc & pwrite_i;
  wire [`SSDC_IRQ_W-1:0] ev = {any_step, wdog_lost, idle_set, ovt_rise};
  reg mapped;
  reg [31:0] rd_mux;
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr_i)
      `SSDC_OFF_CTRL: rd_mux = {23'h0, ctrl_r};
      `SSDC_OFF_STAT: rd_mux = {25'h0, ovt_s, wdog_ok_r, idle_r, ax_dir};
      `SSDC_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
      `SSDC_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
      `SSDC_OFF_POS_X: rd_mux = ax_pos[0];
      `SSDC_OFF_POS_Y: rd_mux = ax_pos[1];
      `SSDC_OFF_POS_Z: rd_mux = ax_pos[2];
      `SSDC_OFF_POS_C: rd_mux = ax_pos[3];
      `SSDC_OFF_CFG: rd_mux = {16'h0, ax_phase[3], ax_phase[2], ax_phase[1], ax_phase[0]};
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= `SSDC_CTRL_RST;
      irq_stat_r <= {`SSDC_IRQ_W{1'b0}};
      irq_mask_r <= {`SSDC_IRQ_W{1'b0}};
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        prdata_o <= rd_mux;
      end
      if (apb_wr & (paddr_i == `SSDC_OFF_CTRL)) begin
        ctrl_r <= pwdata_i[8:0];
      end
      if (apb_wr & (paddr_i == `SSDC_OFF_IRQ_MASK)) begin
        irq_mask_r <= pwdata_i[`SSDC_IRQ_W-1:0];
      end
      // Set wins over write-one-to-clear in the same cycle
      if (apb_wr & (paddr_i == `SSDC_OFF_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~pwdata_i[`SSDC_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
    end
  end

  // Registered outputs
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_pulse_o <= 4'h0;
      dir_o <= 4'h0;
      c_cur_code_o <= `SSDC_CCUR_LOW;
      xyz_cur_hi_o <= 1'b0;
      cur_reduce_o <= 1'b1;
      aux_brake_o <= 1'b0;
      aux_pwm_en_o <= 1'b0;
      ready_o <= 1'b0;
      running_o <= 1'b0;
      fault_led_o <= 6'h00;
      irq_o <= 1'b0;
    end else begin
      step_pulse_o <= ax_pulse;
      dir_o <= ax_dir;
      c_cur_code_o <= ctrl_r[`SSDC_CTRL_CCUR_LSB +: 2];
      xyz_cur_hi_o <= ctrl_r[`SSDC_CTRL_XYZCUR_BIT];
      cur_reduce_o <= idle_r;
      aux_brake_o <= ctrl_r[`SSDC_CTRL_AUX_BIT];
      aux_pwm_en_o <= ~ctrl_r[`SSDC_CTRL_AUX_BIT];
      ready_o <= wdog_ok_r;
      running_o <= ~idle_r;
      fault_led_o <= {6{flash_r}};
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// ---- shared/ssdc_consts.vh ----
// Constants for the step/direction configuration block
`ifndef SSDC_CONSTS_VH
`define SSDC_CONSTS_VH
// APB register byte offsets
`define SSDC_OFF_CTRL 12'h000
`define SSDC_OFF_STAT 12'h004
`define SSDC_OFF_IRQ_STAT 12'h008
`define SSDC_OFF_IRQ_MASK 12'h00c
`define SSDC_OFF_POS_X 12'h010
`define SSDC_OFF_POS_Y 12'h014
`define SSDC_OFF_POS_Z 12'h018
`define SSDC_OFF_POS_C 12'h01c
`define SSDC_OFF_CFG 12'h020
// Control register fields
`define SSDC_CTRL_RES_LSB 0
`define SSDC_CTRL_CCUR_LSB 4
`define SSDC_CTRL_XYZCUR_BIT 6
`define SSDC_CTRL_AUX_BIT 7
`define SSDC_CTRL_OVT_BIT 8
`define SSDC_CTRL_RST 9'h000
// Interrupt status bits
`define SSDC_IRQ_OVT_BIT 0
`define SSDC_IRQ_IDLE_BIT 1
`define SSDC_IRQ_WDOG_BIT 2
`define SSDC_IRQ_STEP_BIT 3
`define SSDC_IRQ_W 4
// Current codes
`define SSDC_CCUR_LOW 2'h0
`define SSDC_CCUR_2A0 2'h1
`define SSDC_CCUR_2A8 2'h2
`define SSDC_CCUR_3A5 2'h3
// Microsteps per full step
`define SSDC_USTEP_FINE 4'ha
`define SSDC_USTEP_COARSE 4'h5
// Timing: clock 125 MHz
`define SSDC_CLK_HZ 125000000
`define SSDC_IDLE_MS 600
`define SSDC_IDLE_CYC ((`SSDC_CLK_HZ / 1000) * `SSDC_IDLE_MS)
`define SSDC_WDOG_MS 50
`define SSDC_WDOG_CYC ((`SSDC_CLK_HZ / 1000) * `SSDC_WDOG_MS)
`define SSDC_FLASH_MS 250
`define SSDC_FLASH_CYC ((`SSDC_CLK_HZ / 1000) * `SSDC_FLASH_MS)
`endif

// ---- sim/ssdc_host.sv ----
// Host model: step, direction and watchdog pins of the parallel port
`timescale 1ns/1ns
module ssdc_host (
  // Clock and watchdog enable
  input wire logic core_clk_i,
  input wire logic wd_en_i,
  // Port pins
  output logic [3:0] step_o,
  output logic [3:0] dir_o,
  output logic watchdog_o
);
  initial begin
    step_o = 4'h0;
    dir_o = 4'h0;
    watchdog_o = 1'b0;
  end
  always @(posedge core_clk_i) if (wd_en_i) watchdog_o <= ~watchdog_o;
  // Width of 2.0 to 2.4 us and a period of 10.0 to 10.4 us keep the rate just under the 100 kHz limit
  task automatic pulse(input logic [3:0] mask, input logic [3:0] d, input int hi);
    dir_o <= d;
    repeat (4) @(posedge core_clk_i);
    step_o <= mask;
    repeat (250 + hi) @(posedge core_clk_i);
    step_o <= 4'h0;
    repeat (1000) @(posedge core_clk_i);
  endtask
endmodule

// ---- sim/ssdc_props.sv ----
// Concurrent checks on the step/direction configuration top
`timescale 1ns/1ns
module ssdc_props #(
  parameter IDLE_CYC = 20,
  parameter WDOG_CYC = 10
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  // Host pins
  input wire [3:0] step_i,
  input wire [3:0] dir_i,
  input wire watchdog_i,
  // Drive and indicators
  input wire [3:0] step_pulse_o,
  input wire [3:0] dir_o,
  input wire [1:0] c_cur_code_o,
  input wire xyz_cur_hi_o,
  input wire aux_brake_o,
  input wire aux_pwm_en_o,
  input wire cur_reduce_o,
  input wire ready_o,
  input wire [5:0] fault_led_o
);
  int idle_cnt;
  int wd_cnt;
  logic wd_q;
  wire ctrl_wr = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == 12'h000);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Margins cover the input synchronisers and the output register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt <= 0;
      wd_cnt <= 0;
      wd_q <= 1'b0;
    end else begin
      wd_q <= watchdog_i;
      idle_cnt <= (step_pulse_o != 4'h0) ? 0 : (idle_cnt < 100000 ? idle_cnt + 1 : idle_cnt);
      wd_cnt <= (wd_q != watchdog_i) ? 0 : (wd_cnt < 100000 ? wd_cnt + 1 : wd_cnt);
    end
  end
  a_step_rise: assert property ($rose(step_i[0]) |-> ##[3:5] step_pulse_o[0])
    else $error("no microstep after rising step edge");
  a_pulse_single: assert property (step_pulse_o[0] |=> !step_pulse_o[0])
    else $error("step pulse longer than one cycle");
  a_dir_capture: assert property (step_pulse_o[0] |-> dir_o[0] == $past(dir_i[0], 3))
    else $error("direction not taken at step edge");
  a_ccur_write: assert property (ctrl_wr |=> ##1 c_cur_code_o == $past(pwdata_i[5:4], 2))
    else $error("C current code does not follow control");
  a_xyz_write: assert property (ctrl_wr |=> ##1 xyz_cur_hi_o == $past(pwdata_i[6], 2))
    else $error("XYZ current does not follow control");
  a_aux_mode: assert property (ctrl_wr |=> ##1 aux_brake_o != aux_pwm_en_o)
    else $error("aux output mode not exclusive");
  a_idle_reduce: assert property (idle_cnt == IDLE_CYC + 6 |-> cur_reduce_o)
    else $error("no current reduction after idle delay");
  a_led_group: assert property (fault_led_o == 6'h00 || fault_led_o == 6'h3f)
    else $error("fault indicators out of phase");
  a_wdog_ready: assert property (wd_cnt == WDOG_CYC + 8 |-> !ready_o)
    else $error("ready kept without watchdog toggling");
endmodule
bind ssdc_top ssdc_props #(.IDLE_CYC(IDLE_CYC), .WDOG_CYC(WDOG_CYC)) ssdc_props_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .step_i(step_i), .dir_i(dir_i), .watchdog_i(watchdog_i), .step_pulse_o(step_pulse_o),
  .dir_o(dir_o), .c_cur_code_o(c_cur_code_o), .xyz_cur_hi_o(xyz_cur_hi_o),
  .aux_brake_o(aux_brake_o), .aux_pwm_en_o(aux_pwm_en_o), .cur_reduce_o(cur_reduce_o),
  .ready_o(ready_o), .fault_led_o(fault_led_o));

// ---- sim/tb_ssdc_top.sv ----
// Self-checking bench for the step/direction configuration top
`timescale 1ns/1ns
module tb_ssdc_top;
  localparam int IDLE = 2000;
  localparam int WDOG = 10;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic overtemp_i = 1'b0;
  logic wd_en = 1'b1;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, watchdog, xyz_cur_hi_o, cur_reduce_o, aux_brake_o, aux_pwm_en_o;
  logic ready_o, irq_o, running_o;
  logic [3:0] step, dir, step_pulse_o, dir_o;
  logic [1:0] c_cur_code_o;
  logic [5:0] fault_led_o;
  int mismatches = 0;
  int tests_run = 0;
  int pos[4];
  int i, k, n;
  logic [31:0] rd;
  logic err, hi_seen, lo_seen;
  logic [3:0] res, m, d;
  always #4 core_clk_i = ~core_clk_i;
  ssdc_host ssdc_host_inst (.core_clk_i(core_clk_i), .wd_en_i(wd_en), .step_o(step),
    .dir_o(dir), .watchdog_o(watchdog));
  ssdc_top #(.IDLE_CYC(IDLE), .WDOG_CYC(WDOG), .FLASH_CYC(4)) ssdc_top_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .step_i(step), .dir_i(dir),
    .watchdog_i(watchdog), .overtemp_i(overtemp_i), .step_pulse_o(step_pulse_o),
    .dir_o(dir_o), .c_cur_code_o(c_cur_code_o), .xyz_cur_hi_o(xyz_cur_hi_o),
    .cur_reduce_o(cur_reduce_o), .aux_brake_o(aux_brake_o), .aux_pwm_en_o(aux_pwm_en_o),
    .ready_o(ready_o), .running_o(running_o), .fault_led_o(fault_led_o), .irq_o(irq_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    // A missing answer counts as a mismatch instead of passing silently
    chk(pready_o, 1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #600000;
    mismatches++;
    finish_test;
  end
  initial begin
    void'($urandom(23));
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 4; i++) begin
      res = $urandom;
      apb(1'b1, 12'h000, {24'h0, i[1:0], i[1:0], res});
      chk(c_cur_code_o, i);
      chk(xyz_cur_hi_o, i & 1);
      chk({aux_brake_o, aux_pwm_en_o}, i[1] ? 2 : 1);
    end
    $display("config codes done");
    for (i = 0; i < 20; i++) begin
      m = (i == 0) ? 4'hf : $urandom;
      d = $urandom;
      ssdc_host_inst.pulse(m, d, $urandom % 50);
      for (k = 0; k < 4; k++) if (m[k]) pos[k] += d[k] ? 1 : -1;
    end
    chk(cur_reduce_o, 0);
    chk(running_o, 1);
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 12'h010 + 12'(4 * k), 32'h0);
      chk(rd, pos[k]);
      apb(1'b0, 12'h020, 32'h0);
      n = res[k] ? 5 : 10;
      chk(rd[4*k +: 4], ((pos[k] % n) + n) % n);
    end
    $display("stepping done");
    repeat (IDLE + 20) @(posedge core_clk_i);
    chk(cur_reduce_o, 1);
    chk(running_o, 0);
    chk(irq_o, 0);
    apb(1'b1, 12'h00c, 32'h2);
    chk(irq_o, 1);
    apb(1'b1, 12'h008, 32'h2);
    chk(irq_o, 0);
    $display("idle reduction done");
    overtemp_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[6], 1);
    hi_seen = 1'b0;
    lo_seen = 1'b0;
    repeat (12) begin
      @(posedge core_clk_i);
      hi_seen |= (fault_led_o === 6'h3f);
      lo_seen |= (fault_led_o === 6'h00);
    end
    chk({hi_seen, lo_seen}, 3);
    overtemp_i <= 1'b0;
    chk(ready_o, 1);
    wd_en <= 1'b0;
    repeat (WDOG + 20) @(posedge core_clk_i);
    chk(ready_o, 0);
    chk(fault_led_o, 0);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1);
    chk(rd, 0);
    $display("faults and watchdog done");
    finish_test;
  end
endmodule
